// ===== sas_cfg.svh
// Contract
// RULE1 - conversion clock up to 18 MHz; each conversion takes at least 18 clocks
// RULE2 - every conversion yields a twelve-bit result for its channel
// RULE3 - eight channels; sequencer steps through enabled ones without processor help
// RULE4 - no idle cycles between channels; aggregate rate stays constant; code idles one cycle per scan restart, stalls while the fifo is full
// RULE5 - channel selection by internal state machine or by firmware, chosen by config
// RULE6 - each channel result held in its own buffer
// RULE7 - sample time configurable per channel, applied when that channel converts
// RULE8 - sample-and-hold aperture length is programmable
// RULE9 - low and high limits held; out-of-range flag raised outside window
// RULE10 - range check done as each conversion completes, not at scan end
// RULE11 - converter and sequencer idle while deep sleep is asserted
// RULE12 - range flag sticky until cleared; buffer overwritten only by its channel
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH
`define SAS_NCH        8
`define SAS_CHW        3
`define SAS_RESW       12
`define SAS_SMPW       8
`define SAS_MAX_CLK_MHZ 18
`define SAS_CONV_CLKS  18
// successive-approximation bit steps after the aperture
`define SAS_BIT_CLKS   (`SAS_CONV_CLKS - 6)
`define SAS_MIN_SMP    8'h06
// wait per bit: code register, then two comparator sync stages
`define SAS_CMP_WAIT   8'h03
`define SAS_FIFO_W     15
`define SAS_FIFO_D     16
`define SAS_FIFO_AW    4
`define SAS_CH_LAST    3'h7
`endif

// ===== sas_pkg.sv
package sas_pkg;
  typedef enum logic [3:0] {
    SAS_IDLE   = 4'h1,
    SAS_SAMPLE = 4'h2,
    SAS_CONV   = 4'h4,
    SAS_DONE   = 4'h8
  } sas_state_t;
endpackage : sas_pkg

// ===== sas_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sas_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : sas_fifo
`default_nettype wire

// ===== sas_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "sas_cfg.svh"
module sas_sequencer (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             deep_sleep,
  input  wire logic                             enable,
  input  wire logic                             fw_select_mode,
  input  wire logic [`SAS_CHW-1:0]              fw_channel,
  input  wire logic                             fw_start,
  input  wire logic [`SAS_NCH-1:0]              chan_enable,
  input  wire logic [`SAS_NCH*`SAS_SMPW-1:0]    chan_sample_time,
  input  wire logic [`SAS_RESW-1:0]             range_low,
  input  wire logic [`SAS_RESW-1:0]             range_high,
  input  wire logic                             range_flag_clear,
  input  wire logic                             cmp_in,
  input  wire logic [`SAS_CHW-1:0]              result_sel,
  output logic [`SAS_CHW-1:0]                   mux_sel,
  output logic                                  sample_hold,
  output logic [`SAS_RESW-1:0]                  dac_code,
  output logic                                  busy,
  output logic                                  scan_done,
  output logic                                  range_irq,
  output logic [`SAS_RESW-1:0]                  result_data,
  output logic [`SAS_FIFO_W-1:0]                fifo_data,
  output logic                                  fifo_valid,
  input  wire logic                             fifo_ready
);
  sas_pkg::sas_state_t state_q;
  logic [`SAS_CHW-1:0]    ch_q;
  logic [`SAS_SMPW-1:0]   cnt_q;
  logic [`SAS_RESW-1:0]   sar_q;
  logic [`SAS_RESW-1:0]   trial_q;
  logic [`SAS_RESW-1:0]   buf_q [`SAS_NCH];
  logic                   cmp_meta_q;
  logic                   cmp_q;
  logic                   sleep_meta_q;
  logic                   sleep_q;
  logic                   fstart_q;
  logic [`SAS_RESW-1:0]   res_d;
  logic                   out_range;
  logic                   fin_last;
  logic [`SAS_CHW-1:0]    next_ch;
  logic                   push_ready;
  logic                   fifo_push;
  logic [`SAS_FIFO_W-1:0] fifo_in;
  logic                   go;
  logic                   last_step;
  logic [`SAS_CHW-1:0]    first_ch;

  // per-channel aperture, floored at 6 clocks; with 12 bits of 4 clocks each a conversion never drops below 54 clocks
  function automatic logic [`SAS_SMPW-1:0] smp_of(input logic [`SAS_CHW-1:0] c);
    logic [`SAS_SMPW-1:0] t;
    t = chan_sample_time[c*`SAS_SMPW +: `SAS_SMPW];
    return (t < `SAS_MIN_SMP) ? `SAS_MIN_SMP : t;
  endfunction : smp_of

  function automatic logic [`SAS_CHW-1:0] next_en(input logic [`SAS_CHW-1:0] c);
    logic [`SAS_CHW-1:0] n;
    logic                hit;
    n   = c;
    hit = 1'b0;
    for (int i = 1; i <= `SAS_NCH; i++) begin
      if (!hit && chan_enable[`SAS_CHW'(c + `SAS_CHW'(i))]) begin
        n   = `SAS_CHW'(c + `SAS_CHW'(i));
        hit = 1'b1;
      end
    end
    return n;
  endfunction : next_en

  // two stages on the comparator and sleep levels, they come from the analog side
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmp_meta_q   <= 1'b0;
      cmp_q        <= 1'b0;
      sleep_meta_q <= 1'b0;
      sleep_q      <= 1'b0;
    end else begin
      cmp_meta_q   <= cmp_in;
      cmp_q        <= cmp_meta_q;
      sleep_meta_q <= deep_sleep;
      sleep_q      <= sleep_meta_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fstart_q <= 1'b0;
    end else if (fw_start) begin
      fstart_q <= 1'b1;
    end else if (state_q == sas_pkg::SAS_IDLE) begin
      fstart_q <= 1'b0;
    end
  end

  assign res_d     = cmp_q ? sar_q : (sar_q & ~trial_q);
  assign out_range = (res_d < range_low) || (res_d > range_high);
  assign next_ch   = next_en(ch_q);
  assign fin_last  = fw_select_mode || (next_ch <= ch_q);
  // a bit is decided only once its trial code has crossed the sync stages
  assign last_step = state_q == sas_pkg::SAS_CONV && cnt_q == `SAS_CMP_WAIT && trial_q[0];
  assign first_ch  = fw_select_mode ? fw_channel : (chan_enable[0] ? '0 : next_en('0));
  // push on the last bit, so the stall test in done sees the true fill level
  assign fifo_push = last_step;
  assign fifo_in   = {ch_q, res_d};
  // RULE5 firmware or machine
  assign go        = enable && !sleep_q && push_ready &&
                     (fw_select_mode ? fstart_q : (chan_enable != '0));

  // RULE11 halt in sleep
  always_ff @(posedge ref_clk) begin
    if (rst || sleep_q || !enable) begin
      state_q     <= sas_pkg::SAS_IDLE;
      ch_q        <= '0;
      cnt_q       <= '0;
      sar_q       <= '0;
      trial_q     <= '0;
      sample_hold <= 1'b0;
      busy        <= 1'b0;
      mux_sel     <= '0;
    end else begin
      case (state_q)
        sas_pkg::SAS_IDLE: begin
          if (go) begin
            // RULE3 first enabled channel
            ch_q        <= first_ch;
            mux_sel     <= first_ch;
            cnt_q       <= '0;
            sample_hold <= 1'b1;
            busy        <= 1'b1;
            state_q     <= sas_pkg::SAS_SAMPLE;
          end
        end
        sas_pkg::SAS_SAMPLE: begin
          // RULE7 per-channel time
          // RULE8 programmable aperture
          if (cnt_q == smp_of(ch_q) - 1'b1) begin
            sample_hold <= 1'b0;
            cnt_q       <= '0;
            sar_q       <= {1'b1, {(`SAS_RESW-1){1'b0}}};
            trial_q     <= {1'b1, {(`SAS_RESW-1){1'b0}}};
            state_q     <= sas_pkg::SAS_CONV;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        sas_pkg::SAS_CONV: begin
          // RULE1 twelve bit steps
          // RULE2 twelve-bit result
          if (cnt_q == `SAS_CMP_WAIT) begin
            cnt_q   <= '0;
            sar_q   <= res_d | (trial_q >> 1);
            trial_q <= trial_q >> 1;
            if (trial_q[0]) begin
              sar_q   <= res_d;
              state_q <= sas_pkg::SAS_DONE;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        sas_pkg::SAS_DONE: begin
          // RULE4 next channel straight from done if the fifo has room; last channel returns to idle
          if (!fin_last && push_ready) begin
            ch_q        <= next_ch;
            mux_sel     <= next_ch;
            cnt_q       <= '0;
            sample_hold <= 1'b1;
            state_q     <= sas_pkg::SAS_SAMPLE;
          end else begin
            busy    <= !fin_last;
            state_q <= fin_last ? sas_pkg::SAS_IDLE : sas_pkg::SAS_DONE;
          end
        end
        default: state_q <= sas_pkg::SAS_IDLE;
      endcase
    end
  end

  // RULE6 buffer per channel
  // RULE12 own channel only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < `SAS_NCH; i++) begin
        buf_q[i] <= '0;
      end
    end else if (last_step) begin
      buf_q[ch_q] <= res_d;
    end
  end

  // RULE9 window flag
  // RULE10 checked per conversion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      range_irq <= 1'b0;
    end else if (last_step && out_range) begin
      range_irq <= 1'b1;
    end else if (range_flag_clear) begin
      range_irq <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scan_done   <= 1'b0;
    end else begin
      scan_done   <= state_q == sas_pkg::SAS_DONE && fin_last;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dac_code    <= '0;
      result_data <= '0;
    end else begin
      dac_code    <= sar_q;
      result_data <= buf_q[result_sel];
    end
  end

  // sequencer stalls before a channel whose result would find no room
  sas_fifo #(
    .WIDTH (`SAS_FIFO_W),
    .DEPTH (`SAS_FIFO_D),
    .AW    (`SAS_FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (fifo_in),
    .in_valid  (fifo_push),
    .in_ready  (push_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );
endmodule : sas_sequencer
`default_nettype wire

// ===== sas_sequencer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        deep_sleep,
  input wire logic        enable,
  input wire logic        fw_select_mode,
  input wire logic [2:0]  fw_channel,
  input wire logic        fw_start,
  input wire logic [7:0]  chan_enable,
  input wire logic [63:0] chan_sample_time,
  input wire logic        range_flag_clear,
  input wire logic [2:0]  mux_sel,
  input wire logic        sample_hold,
  input wire logic        busy,
  input wire logic        range_irq
);
  logic [7:0] hold_q;
  logic [7:0] t_sel;
  assign t_sel = chan_sample_time[{mux_sel, 3'h0} +: 8];
  always_ff @(posedge ref_clk) hold_q <= (rst || !sample_hold) ? 8'h00 : hold_q + 8'h01;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_hold_len: assert property (
    $fell(sample_hold) && busy |-> hold_q == ((t_sel < 8'h06) ? 8'h06 : t_sel))
    else $error("aperture");
  a_conv_len: assert property (
    $fell(sample_hold) |-> (!sample_hold)[*8] ##1 (!sample_hold)[*4]) else $error("short conv");
  // sleep goes through a 2-ff sync, so allow settling
  a_sleep_idle: assert property (deep_sleep[*7] |-> !busy)
    else $error("busy in sleep");
  a_irq_sticky: assert property (range_irq && !range_flag_clear |=> range_irq)
    else $error("irq dropped");
  a_mux_hold: assert property ($past(sample_hold) && sample_hold |-> $stable(mux_sel))
    else $error("mux moved");
  a_fw_chan: assert property (
    fw_select_mode && $rose(sample_hold) |-> mux_sel == fw_channel) else $error("fw chan");
  a_scan_chan: assert property (
    !fw_select_mode && $rose(sample_hold) |-> chan_enable[mux_sel]) else $error("scan chan");
  a_fw_go: assert property (
    fw_select_mode && enable && fw_start && !busy |-> ##[1:3] sample_hold) else $error("no go");
endmodule : sas_sequencer_chk
bind sas_sequencer sas_sequencer_chk sas_sequencer_chk_inst (.ref_clk, .rst, .deep_sleep,
  .enable, .fw_select_mode, .fw_channel, .fw_start, .chan_enable, .chan_sample_time,
  .range_flag_clear, .mux_sel, .sample_hold, .busy, .range_irq);
`default_nettype wire

// ===== sas_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module sas_core_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  mux_sel,
  input  wire logic        sample_hold,
  input  wire logic [11:0] dac_code,
  input  wire logic [95:0] levels,
  output logic             cmp_in
);
  logic [11:0] held_q;
  always_ff @(posedge ref_clk) begin
    if (rst) held_q <= 12'h000;
    else if (sample_hold) held_q <= levels[mux_sel*12 +: 12];
  end
  assign cmp_in = held_q >= dac_code;
endmodule : sas_core_model
`default_nettype wire

// ===== test_sas_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_sas_sequencer;
  logic        ref_clk = 1'b0, rst = 1'b1, deep_sleep = 1'b0, enable = 1'b0;
  logic        fw_select_mode = 1'b0, fw_start = 1'b0, range_flag_clear = 1'b0;
  logic        fifo_ready = 1'b0, cmp_in, sample_hold, busy, scan_done, range_irq, fifo_valid;
  logic [2:0]  fw_channel = 3'h0, result_sel = 3'h0, mux_sel;
  logic [7:0]  chan_enable = 8'ha5;
  logic [63:0] chan_sample_time = 64'h0;
  logic [11:0] range_low = 12'h100, range_high = 12'h800, dac_code, result_data, lv;
  logic [14:0] fifo_data;
  logic [95:0] levels = 96'h0;
  logic [11:0] last_res [8] = '{default: 12'h000};
  logic [14:0] exp_q [$];
  int          err_total = 0, tests_run = 0, seed = 32'hfef2, i, n, cnt, dn = 0;
  bit          skip = 1'b1;
  always #5 ref_clk = ~ref_clk;
  sas_sequencer sas_sequencer_inst (.ref_clk, .rst, .deep_sleep, .enable, .fw_select_mode,
    .fw_channel, .fw_start, .chan_enable, .chan_sample_time, .range_low, .range_high,
    .range_flag_clear, .cmp_in, .result_sel, .mux_sel, .sample_hold, .dac_code, .busy,
    .scan_done, .range_irq, .result_data, .fifo_data, .fifo_valid, .fifo_ready);
  sas_core_model sas_core_model_inst (.ref_clk, .rst, .mux_sel, .sample_hold, .dac_code,
    .levels, .cmp_in);
  task automatic check(input logic [14:0] got, input logic [14:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out;
    $display("errors=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // scan mode restarts after every scan, so only the queue ends that wait
  task automatic wait_q(input bit scan);
    for (n = 0; n < 3000 && (exp_q.size() != 0 || (!scan && busy !== 1'b0)); n++) begin
      @(negedge ref_clk);
      if (scan) fifo_ready = 1'($random(seed));
    end
    if (n == 3000) begin
      err_total++;
      close_out();
    end
  endtask : wait_q
  always @(posedge ref_clk) begin
    if (fifo_valid === 1'b1 && fifo_ready === 1'b1 && !skip) begin
      check(fifo_data, exp_q.size() != 0 ? exp_q.pop_front() : ~fifo_data);
    end
    if (scan_done === 1'b1) dn++;
  end
  initial begin
    for (i = 0; i < 8; i++) begin
      levels[i*12 +: 12] = 12'($random(seed));
      chan_sample_time[i*8 +: 8] = 8'(2 * i + 1);
    end
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < 48; i++) begin
      if (chan_enable[i%8]) begin
        exp_q.push_back({3'(i % 8), levels[(i%8)*12 +: 12]});
        last_res[i%8] = levels[(i%8)*12 +: 12];
      end
    end
    skip = 1'b0;
    enable = 1'b1;
    repeat (1200) @(negedge ref_clk);
    cnt = 0;
    for (n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      cnt += sample_hold;
    end
    check(15'(cnt), 15'h0);
    wait_q(1'b1);
    fifo_ready = 1'b1;
    skip = 1'b1;
    deep_sleep = 1'b1;
    repeat (10) @(negedge ref_clk);
    cnt = 0;
    for (n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      cnt += busy;
    end
    check(15'(cnt), 15'h0);
    enable = 1'b0;
    deep_sleep = 1'b0;
    range_flag_clear = 1'b1;
    @(negedge ref_clk);
    range_flag_clear = 1'b0;
    repeat (60) @(negedge ref_clk);
    check({14'h0, range_irq}, 15'h0);
    dn = 0;
    fw_select_mode = 1'b1;
    enable = 1'b1;
    skip = 1'b0;
    for (i = 0; i < 4; i++) begin
      lv = (i == 0) ? 12'h0ff : (i == 1) ? 12'h100 : (i == 2) ? 12'h800 : 12'h801;
      levels[(i+1)*12 +: 12] = lv;
      last_res[i+1] = lv;
      exp_q.push_back({3'(i + 1), lv});
      fw_channel = 3'(i + 1);
      fw_start = 1'b1;
      @(negedge ref_clk);
      fw_start = 1'b0;
      repeat (3) @(negedge ref_clk);
      wait_q(1'b0);
      check({14'h0, range_irq}, {14'h0, i != 2});
      if (i % 2 == 1) begin
        range_flag_clear = 1'b1;
        @(negedge ref_clk);
        range_flag_clear = 1'b0;
        @(negedge ref_clk);
        check({14'h0, range_irq}, 15'h0);
      end
    end
    check(15'(dn), 15'h4);
    for (i = 0; i < 8; i++) begin
      result_sel = 3'(i);
      repeat (2) @(negedge ref_clk);
      check({3'h0, result_data}, {3'h0, last_res[i]});
    end
    close_out();
  end
endmodule : test_sas_sequencer
`default_nettype wire
